/* src/sag_pkg.sv */
// sag_pkg: constants and carriers for the segment address generator
// assumes: a single 100 MHz clock domain, 16-bit segments and offsets
package sag_pkg;

  // ---------------------------------------------------------------
  // widths and reset values
  // ---------------------------------------------------------------
  localparam int SEG_W = 16;
  localparam int PHYS_W = 20;
  localparam logic [15:0] CODE_SEG_RST = 16'hFFFF;
  localparam logic [15:0] FETCH_OFS_RST = 16'h0000;
  localparam logic [15:0] DATA_SEG_RST = 16'h0000;
  localparam logic [15:0] STACK_WORD_STEP = 16'h0002;
  localparam logic [15:0] BYTE_STEP = 16'h0001;

  // ---------------------------------------------------------------
  // reserved regions
  // ---------------------------------------------------------------
  localparam logic [19:0] VEC_LO = 20'h00000;
  localparam logic [19:0] VEC_HI = 20'h003FF;
  localparam logic [19:0] BOOT_LO = 20'hFFFF0;
  localparam logic [15:0] IO_RSV_LO = 16'h00F8;
  localparam logic [15:0] IO_RSV_HI = 16'h00FF;

  // ---------------------------------------------------------------
  // AXI4-Lite register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CODE_SEG = 8'h00;
  localparam logic [7:0] OFS_DATA_SEG = 8'h04;
  localparam logic [7:0] OFS_STACK_SEG = 8'h08;
  localparam logic [7:0] OFS_EXTRA_SEG = 8'h0C;
  localparam logic [7:0] OFS_FETCH = 8'h10;
  localparam logic [7:0] OFS_STACK_TOP = 8'h14;
  localparam logic [7:0] OFS_SRC_IDX = 8'h18;
  localparam logic [7:0] OFS_DST_IDX = 8'h1C;
  localparam logic [7:0] OFS_CTRL = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam int CTRL_DIR_BIT = 0;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ---------------------------------------------------------------
  // reference kinds and segment selects
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SAG_REF_FETCH = 3'h0,
    SAG_REF_STACK = 3'h1,
    SAG_REF_VAR = 3'h2,
    SAG_REF_STR_SRC = 3'h3,
    SAG_REF_STR_DST = 3'h4,
    SAG_REF_FRAME = 3'h5,
    SAG_REF_IO = 3'h6
  } sag_ref_t;

  typedef enum logic [1:0] {
    SAG_SEG_EXTRA = 2'h0,
    SAG_SEG_CODE = 2'h1,
    SAG_SEG_STACK = 2'h2,
    SAG_SEG_DATA = 2'h3
  } sag_seg_t;

  typedef enum logic [1:0] {
    SAG_STK_NONE = 2'h0,
    SAG_STK_PUSH = 2'h1,
    SAG_STK_POP = 2'h2
  } sag_stk_t;

  // request from the execution unit
  typedef struct packed {
    logic valid;
    sag_ref_t kind;
    logic ovr_en;
    sag_seg_t ovr_seg;
    logic [15:0] effective_offset;
    sag_stk_t stk_op;
    logic str_word;
    logic str_step;
  } sag_req_t;

  // answer toward the bus cycle logic
  typedef struct packed {
    logic valid;
    logic [19:0] phys_addr;
    sag_seg_t seg_used;
    logic is_io;
    logic word;
    logic vec_region;
    logic boot_region;
    logic io_reserved;
  } sag_rsp_t;

endpackage : sag_pkg

/* src/sag_core.sv */
// sag_core: segment selection, physical address forming, pointer updates
// assumes: requests come from the execution unit on core_clk, one per cycle;
// software reaches the segment and pointer registers over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - fetches use code segment and fetch pointer
// - stack references use stack segment, stack pointer
// - variables default data segment, overridable
// - string source uses data segment, overridable
// - string destination always extra segment
// - string index registers step per element
// - frame base references default to stack
// - push decrements by two then writes
// - pop reads then increments by two
// - stack transfers are whole words
// - stack offset wraps inside segment
// - first fetch after reset at FFFF0
// - io ports F8 to FF reserved
// - physical addresses are twenty bits
// - reset values of segments and fetch pointer
module sag_core (
  input wire logic core_clk, // system clock
  input wire logic rst_b, // synchronous reset, active low
  input wire sag_pkg::sag_req_t req, // reference request
  input wire logic fetch_adv, // fetch pointer advance strobe
  input wire logic [2:0] fetch_len, // bytes consumed by the fetch
  output sag_pkg::sag_rsp_t rsp, // registered address answer
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);

  // ---------------------------------------------------------------
  // segment and pointer registers
  // ---------------------------------------------------------------
  logic [15:0] code_seg_reg, data_seg_base_reg, stack_seg_reg, extra_seg_base_reg;
  logic [15:0] fetch_offset_ptr_reg, stack_top_ptr_reg;
  logic [15:0] string_src_index_reg, string_dst_index_reg;
  logic dir_down_reg;
  logic [15:0] seg_base;
  logic [15:0] ofs, stk_ofs;
  sag_pkg::sag_seg_t seg_sel;
  logic [19:0] phys;
  logic [15:0] stk_dec, stk_inc, idx_step, src_next, dst_next, fetch_next;
  logic ovr_ok, vec_hit, boot_hit, io_hit;
  logic last_vec_reg, last_io_reg, boot_pending_reg;

  // ---------------------------------------------------------------
  // segment choice per reference kind
  // ---------------------------------------------------------------
  // override accepted only where allowed
  assign ovr_ok = req.ovr_en && (req.kind == sag_pkg::SAG_REF_VAR
                 || req.kind == sag_pkg::SAG_REF_STR_SRC
                 || req.kind == sag_pkg::SAG_REF_FRAME);
  assign stk_ofs = (req.stk_op == sag_pkg::SAG_STK_PUSH) ? stk_dec : stack_top_ptr_reg;
  assign ofs = (req.kind == sag_pkg::SAG_REF_FETCH) ? fetch_offset_ptr_reg :
               (req.kind == sag_pkg::SAG_REF_STACK) ? stk_ofs :
               (req.kind == sag_pkg::SAG_REF_STR_SRC) ? string_src_index_reg :
               (req.kind == sag_pkg::SAG_REF_STR_DST) ? string_dst_index_reg :
               req.effective_offset;
  assign seg_sel = (req.kind == sag_pkg::SAG_REF_FETCH) ? sag_pkg::SAG_SEG_CODE :
                   (req.kind == sag_pkg::SAG_REF_STACK) ? sag_pkg::SAG_SEG_STACK :
                   (req.kind == sag_pkg::SAG_REF_STR_DST) ? sag_pkg::SAG_SEG_EXTRA :
                   ovr_ok ? req.ovr_seg :
                   (req.kind == sag_pkg::SAG_REF_FRAME) ? sag_pkg::SAG_SEG_STACK :
                   sag_pkg::SAG_SEG_DATA;

  // base lookup
  assign seg_base = (seg_sel == sag_pkg::SAG_SEG_CODE) ? code_seg_reg :
                    (seg_sel == sag_pkg::SAG_SEG_STACK) ? stack_seg_reg :
                    (seg_sel == sag_pkg::SAG_SEG_EXTRA) ? extra_seg_base_reg :
                    data_seg_base_reg;
  assign phys = (req.kind == sag_pkg::SAG_REF_IO) ? {4'h0, req.effective_offset}
              : 20'({seg_base, 4'h0} + {4'h0, ofs});
  assign vec_hit = req.kind != sag_pkg::SAG_REF_IO && phys <= sag_pkg::VEC_HI;
  assign boot_hit = req.kind != sag_pkg::SAG_REF_IO && phys >= sag_pkg::BOOT_LO;
  assign io_hit = req.kind == sag_pkg::SAG_REF_IO && req.effective_offset >= sag_pkg::IO_RSV_LO
                  && req.effective_offset <= sag_pkg::IO_RSV_HI;

  assign stk_dec = 16'(stack_top_ptr_reg - sag_pkg::STACK_WORD_STEP);
  assign stk_inc = 16'(stack_top_ptr_reg + sag_pkg::STACK_WORD_STEP);
  // element step by size and direction
  assign idx_step = req.str_word ? sag_pkg::STACK_WORD_STEP : sag_pkg::BYTE_STEP;
  assign src_next = dir_down_reg ? 16'(string_src_index_reg - idx_step)
                                 : 16'(string_src_index_reg + idx_step);
  assign dst_next = dir_down_reg ? 16'(string_dst_index_reg - idx_step)
                                 : 16'(string_dst_index_reg + idx_step);
  assign fetch_next = 16'(fetch_offset_ptr_reg + {13'h0, fetch_len});

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  logic [7:0] aw_reg;
  logic aw_have_reg, w_have_reg;
  logic [31:0] wd_reg;
  logic do_wr;
  logic wr_hit, rd_hit;
  logic [31:0] rd_val;
  logic [15:0] wval;
  assign do_wr = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign wval = wd_reg[15:0];
  assign wr_hit = aw_reg <= sag_pkg::OFS_CTRL && aw_reg[1:0] == 2'b00;
  assign rd_hit = s_axi_araddr <= sag_pkg::OFS_STATUS && s_axi_araddr[1:0] == 2'b00;
  assign rd_val = (s_axi_araddr == sag_pkg::OFS_CODE_SEG) ? {16'h0, code_seg_reg} :
                  (s_axi_araddr == sag_pkg::OFS_DATA_SEG) ? {16'h0, data_seg_base_reg} :
                  (s_axi_araddr == sag_pkg::OFS_STACK_SEG) ? {16'h0, stack_seg_reg} :
                  (s_axi_araddr == sag_pkg::OFS_EXTRA_SEG) ? {16'h0, extra_seg_base_reg} :
                  (s_axi_araddr == sag_pkg::OFS_FETCH) ? {16'h0, fetch_offset_ptr_reg} :
                  (s_axi_araddr == sag_pkg::OFS_STACK_TOP) ? {16'h0, stack_top_ptr_reg} :
                  (s_axi_araddr == sag_pkg::OFS_SRC_IDX) ? {16'h0, string_src_index_reg} :
                  (s_axi_araddr == sag_pkg::OFS_DST_IDX) ? {16'h0, string_dst_index_reg} :
                  (s_axi_araddr == sag_pkg::OFS_CTRL) ? {31'h0, dir_down_reg} :
                  (s_axi_araddr == sag_pkg::OFS_STATUS) ? {30'h0, last_io_reg, last_vec_reg}
                  : 32'h0;

  // write channel capture and response
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_reg <= 8'h00;
      wd_reg <= 32'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sag_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_reg <= 1'b1;
        aw_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_reg <= 1'b1;
        // high byte kept only under its strobe
        wd_reg <= {s_axi_wdata[31:16], s_axi_wstrb[1] ? s_axi_wdata[15:8] : 8'h00, s_axi_wdata[7:0]};
      end
      if (do_wr)
      begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? sag_pkg::RESP_OKAY : sag_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end
  assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_have_reg && !s_axi_bvalid;

  // read channel
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= sag_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_hit ? sag_pkg::RESP_OKAY : sag_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
  assign s_axi_arready = !s_axi_rvalid;

  // ---------------------------------------------------------------
  // register updates: software writes, then hardware stepping
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      // reset values, first fetch at boot area
      code_seg_reg <= sag_pkg::CODE_SEG_RST;
      fetch_offset_ptr_reg <= sag_pkg::FETCH_OFS_RST;
      data_seg_base_reg <= sag_pkg::DATA_SEG_RST;
      extra_seg_base_reg <= sag_pkg::DATA_SEG_RST;
      stack_seg_reg <= sag_pkg::DATA_SEG_RST;
      stack_top_ptr_reg <= sag_pkg::DATA_SEG_RST;
      string_src_index_reg <= sag_pkg::DATA_SEG_RST;
      string_dst_index_reg <= sag_pkg::DATA_SEG_RST;
      dir_down_reg <= 1'b0;
      boot_pending_reg <= 1'b1;
    end
    else
    begin
      if (do_wr && wr_hit)
      begin
        case (aw_reg)
          sag_pkg::OFS_CODE_SEG: code_seg_reg <= wval;
          sag_pkg::OFS_DATA_SEG: data_seg_base_reg <= wval;
          sag_pkg::OFS_STACK_SEG: stack_seg_reg <= wval;
          sag_pkg::OFS_EXTRA_SEG: extra_seg_base_reg <= wval;
          sag_pkg::OFS_FETCH: fetch_offset_ptr_reg <= wval;
          sag_pkg::OFS_STACK_TOP: stack_top_ptr_reg <= wval;
          sag_pkg::OFS_SRC_IDX: string_src_index_reg <= wval;
          sag_pkg::OFS_DST_IDX: string_dst_index_reg <= wval;
          sag_pkg::OFS_CTRL: dir_down_reg <= wval[sag_pkg::CTRL_DIR_BIT];
          default: dir_down_reg <= dir_down_reg;
        endcase
      end
      // hardware steps win over a write in the same cycle
      if (fetch_adv)
        fetch_offset_ptr_reg <= fetch_next;
      // stack pointer after push or pop
      if (req.valid && req.kind == sag_pkg::SAG_REF_STACK)
      begin
        if (req.stk_op == sag_pkg::SAG_STK_PUSH)
          stack_top_ptr_reg <= stk_dec;
        else if (req.stk_op == sag_pkg::SAG_STK_POP)
          stack_top_ptr_reg <= stk_inc;
      end
      // index step once the element is done
      if (req.valid && req.str_step && req.kind == sag_pkg::SAG_REF_STR_SRC)
        string_src_index_reg <= src_next;
      if (req.valid && req.str_step && req.kind == sag_pkg::SAG_REF_STR_DST)
        string_dst_index_reg <= dst_next;
      // boot target stands until first activity
      if (req.valid || fetch_adv || do_wr)
        boot_pending_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // registered answer toward the bus cycle logic
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      rsp <= '0;
      last_vec_reg <= 1'b0;
      last_io_reg <= 1'b0;
    end
    else
    begin
      rsp.valid <= req.valid;
      rsp.phys_addr <= phys;
      rsp.seg_used <= seg_sel;
      rsp.is_io <= req.kind == sag_pkg::SAG_REF_IO;
      rsp.word <= (req.kind == sag_pkg::SAG_REF_STACK) ? 1'b1 : req.str_word;
      rsp.vec_region <= req.valid && vec_hit;
      rsp.boot_region <= req.valid && boot_hit;
      rsp.io_reserved <= req.valid && io_hit;
      // status keeps the flags of the last request
      if (req.valid)
      begin
        last_vec_reg <= vec_hit;
        last_io_reg <= io_hit;
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_fetch_code;
    @(posedge core_clk) disable iff (!rst_b)
    req.valid && req.kind == sag_pkg::SAG_REF_FETCH |=> rsp.seg_used == sag_pkg::SAG_SEG_CODE;
  endproperty
  a_fetch_code: assert property (p_fetch_code) else $error("fetch not in code segment");
  property p_stack_seg;
    @(posedge core_clk) disable iff (!rst_b)
    req.valid && req.kind == sag_pkg::SAG_REF_STACK |=> rsp.seg_used == sag_pkg::SAG_SEG_STACK;
  endproperty
  a_stack_seg: assert property (p_stack_seg) else $error("stack not in stack segment");
  property p_dst_extra;
    @(posedge core_clk) disable iff (!rst_b)
    req.valid && req.kind == sag_pkg::SAG_REF_STR_DST |=> rsp.seg_used == sag_pkg::SAG_SEG_EXTRA;
  endproperty
  a_dst_extra: assert property (p_dst_extra) else $error("string dest not extra");
  property p_var_default;
    @(posedge core_clk) disable iff (!rst_b)
    req.valid && req.kind == sag_pkg::SAG_REF_VAR && !req.ovr_en
      |=> rsp.seg_used == sag_pkg::SAG_SEG_DATA;
  endproperty
  a_var_default: assert property (p_var_default) else $error("variable default wrong");
  property p_frame_default;
    @(posedge core_clk) disable iff (!rst_b)
    req.valid && req.kind == sag_pkg::SAG_REF_FRAME && !req.ovr_en
      |=> rsp.seg_used == sag_pkg::SAG_SEG_STACK;
  endproperty
  a_frame_default: assert property (p_frame_default) else $error("frame default wrong");
  property p_push;
    @(posedge core_clk) disable iff (!rst_b)
    req.valid && req.kind == sag_pkg::SAG_REF_STACK && req.stk_op == sag_pkg::SAG_STK_PUSH
      |=> stack_top_ptr_reg == 16'($past(stack_top_ptr_reg) - 16'h0002)
          && rsp.phys_addr[3:0] == stack_top_ptr_reg[3:0];
  endproperty
  a_push: assert property (p_push) else $error("push pointer wrong");
  property p_pop;
    @(posedge core_clk) disable iff (!rst_b)
    req.valid && req.kind == sag_pkg::SAG_REF_STACK && req.stk_op == sag_pkg::SAG_STK_POP
      |=> stack_top_ptr_reg == 16'($past(stack_top_ptr_reg) + 16'h0002) && rsp.word;
  endproperty
  a_pop: assert property (p_pop) else $error("pop pointer wrong");
  property p_first_fetch;
    @(posedge core_clk) disable iff (!rst_b)
    boot_pending_reg && req.valid && req.kind == sag_pkg::SAG_REF_FETCH
      |=> rsp.phys_addr == sag_pkg::BOOT_LO;
  endproperty
  a_first_fetch: assert property (p_first_fetch) else $error("first fetch address wrong");

endmodule // sag_core

`default_nettype wire

/* tb/sag_bus_model.sv */
// sag_bus_model: bus cycle side, tallies cycles that land in reserved places
// assumes: rsp of sag_core on core_clk, one answer per rsp.valid
`timescale 1ns/1ps
`default_nettype none
module sag_bus_model (
  input wire logic core_clk, // system clock
  input wire logic rst_b, // synchronous reset, active low
  input wire sag_pkg::sag_rsp_t rsp, // address answer
  output logic [15:0] vec_hits, // memory cycles into the vector area
  output logic [15:0] rsv_io_hits // io cycles onto reserved ports
);
  // reserved places decoded from the address and the io flag
  wire logic in_vec = !rsp.is_io && (rsp.phys_addr <= sag_pkg::VEC_HI);
  wire logic in_rsv = rsp.is_io && (rsp.phys_addr[15:0] >= sag_pkg::IO_RSV_LO)
    && (rsp.phys_addr[15:0] <= sag_pkg::IO_RSV_HI);
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      vec_hits <= 16'h0000;
      rsv_io_hits <= 16'h0000;
    end
    else if (rsp.valid)
    begin
      vec_hits <= vec_hits + {15'h0000, in_vec};
      rsv_io_hits <= rsv_io_hits + {15'h0000, in_rsv};
    end
  end
endmodule // sag_bus_model
`default_nettype wire

/* tb/segment_address_generator_bench.sv */
// segment_address_generator_bench: self-checking bench for sag_core
// assumes: sag_pkg, sag_core and sag_bus_model compiled before it
`timescale 1ns/1ps
`default_nettype none
module segment_address_generator_bench;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  sag_pkg::sag_req_t req = '0;
  logic fetch_adv = 1'b0;
  logic [2:0] fetch_len = 3'h0;
  sag_pkg::sag_rsp_t rsp;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic [15:0] vec_hits;
  logic [15:0] rsv_io_hits;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  int exp_vec = 0;
  int exp_rsv = 0;
  // shadow: code, data, stack, extra, fetch, stack top, src idx, dst idx
  logic [15:0] sh [0:7];
  logic dir_dn = 1'b0;

  sag_core sag_core_i (.core_clk(core_clk), .rst_b(rst_b), .req(req), .fetch_adv(fetch_adv),
    .fetch_len(fetch_len), .rsp(rsp), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  sag_bus_model sag_bus_model_i (.core_clk(core_clk), .rst_b(rst_b), .rsp(rsp),
    .vec_hits(vec_hits), .rsv_io_hits(rsv_io_hits));

  // clock and hang guard
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      summarize();
    end
  end

  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // ---------------------------------------------------------------
  // register bus master
  // ---------------------------------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge core_clk);
      if (!aw_ok && s_axi_awready === 1'b1)
      begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1)
      begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1)
      @(posedge core_clk);
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, er);
    if (er == sag_pkg::RESP_OKAY && a < sag_pkg::OFS_CTRL)
      sh[a[4:2]] = d;
    if (a == sag_pkg::OFS_CTRL)
      dir_dn = d[sag_pkg::CTRL_DIR_BIT];
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rr);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    rr = s_axi_rresp;
  endtask

  // ---------------------------------------------------------------
  // request driver with expected answer
  // ---------------------------------------------------------------
  task automatic send(input sag_pkg::sag_req_t r);
    sag_pkg::sag_seg_t s;
    logic [15:0] o;
    logic [15:0] sb;
    logic [15:0] st;
    logic [19:0] pa;
    logic io;
    io = (r.kind == sag_pkg::SAG_REF_IO);
    st = r.str_word ? 16'h0002 : 16'h0001;
    s = r.ovr_en ? r.ovr_seg : sag_pkg::SAG_SEG_DATA;
    o = r.effective_offset;
    if (r.kind == sag_pkg::SAG_REF_FETCH)
    begin
      s = sag_pkg::SAG_SEG_CODE;
      o = sh[4];
    end
    if (r.kind == sag_pkg::SAG_REF_STACK)
    begin
      s = sag_pkg::SAG_SEG_STACK;
      if (r.stk_op == sag_pkg::SAG_STK_PUSH)
        sh[5] = sh[5] - sag_pkg::STACK_WORD_STEP;
      o = sh[5];
    end
    if (r.kind == sag_pkg::SAG_REF_STR_SRC)
      o = sh[6];
    if (r.kind == sag_pkg::SAG_REF_STR_DST)
    begin
      s = sag_pkg::SAG_SEG_EXTRA;
      o = sh[7];
    end
    if (r.kind == sag_pkg::SAG_REF_FRAME && !r.ovr_en)
      s = sag_pkg::SAG_SEG_STACK;
    case (s)
      sag_pkg::SAG_SEG_CODE: sb = sh[0];
      sag_pkg::SAG_SEG_DATA: sb = sh[1];
      sag_pkg::SAG_SEG_STACK: sb = sh[2];
      default: sb = sh[3];
    endcase
    pa = io ? {4'h0, o} : ({sb, 4'h0} + {4'h0, o});
    @(posedge core_clk);
    req <= r;
    @(posedge core_clk);
    req.valid <= 1'b0;
    #1;
    chk("phys", rsp.phys_addr, pa);
    chk("valid", rsp.valid, 1'b1);
    chk("io flag", rsp.is_io, io);
    if (!io)
    begin
      chk("segment", rsp.seg_used, s);
      chk("vector flag", rsp.vec_region, pa <= sag_pkg::VEC_HI);
      chk("boot flag", rsp.boot_region, pa >= sag_pkg::BOOT_LO);
      exp_vec += (pa <= sag_pkg::VEC_HI);
    end
    else
    begin
      chk("io reserved", rsp.io_reserved, o >= 16'h00F8 && o <= 16'h00FF);
      exp_rsv += (o >= 16'h00F8 && o <= 16'h00FF);
    end
    if (r.kind == sag_pkg::SAG_REF_STACK)
      chk("stack word", rsp.word, 1'b1);
    if (r.kind == sag_pkg::SAG_REF_STACK && r.stk_op == sag_pkg::SAG_STK_POP)
      sh[5] = sh[5] + sag_pkg::STACK_WORD_STEP;
    if (r.str_step && r.kind == sag_pkg::SAG_REF_STR_SRC)
      sh[6] = dir_dn ? sh[6] - st : sh[6] + st;
    if (r.str_step && r.kind == sag_pkg::SAG_REF_STR_DST)
      sh[7] = dir_dn ? sh[7] - st : sh[7] + st;
  endtask

  function automatic sag_pkg::sag_req_t mk(input int k, input logic [15:0] ofs);
    sag_pkg::sag_req_t r;
    r = '0;
    r.valid = 1'b1;
    r.kind = sag_pkg::sag_ref_t'(k);
    r.effective_offset = ofs;
    return r;
  endfunction

  // readback of every pointer register against the shadow
  task automatic check_regs();
    logic [31:0] d;
    logic [1:0] rr;
    for (int i = 0; i < 8; i++)
    begin
      axi_rd(8'(i * 4), d, rr);
      chk("register", d[15:0], sh[i]);
    end
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    sag_pkg::sag_req_t r;
    logic [31:0] d;
    logic [1:0] rr;
    void'($urandom(32'hA751));
    sh = '{16'hFFFF, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    send(mk(0, 16'h0000));
    chk("first fetch", rsp.phys_addr, 20'hFFFF0);
    check_regs();
    axi_rd(8'h40, d, rr);
    chk("unmapped resp", rr, sag_pkg::RESP_SLVERR);
    chk("unmapped data", d, 32'h00000000);
    axi_wr(sag_pkg::OFS_STATUS, 16'h0003, sag_pkg::RESP_SLVERR);
    // vector boundary, then twenty bit truncation
    send(mk(2, 16'h03FF));
    send(mk(2, 16'h0400));
    axi_wr(sag_pkg::OFS_DATA_SEG, 16'hFFFF, sag_pkg::RESP_OKAY);
    send(mk(2, 16'hFFFF));
    // stack wrap at offset zero, push then pop
    axi_wr(sag_pkg::OFS_STACK_TOP, 16'h0000, sag_pkg::RESP_OKAY);
    // partial strobe leaves the high byte zero
    s_axi_wstrb <= 4'h1;
    axi_wr(sag_pkg::OFS_SRC_IDX, 16'h12AB, sag_pkg::RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    sh[6] = 16'h00AB;
    r = mk(1, 16'h0000);
    r.stk_op = sag_pkg::SAG_STK_PUSH;
    send(r);
    r.stk_op = sag_pkg::SAG_STK_POP;
    send(r);
    check_regs();
    // every kind except io under every override
    for (int k = 0; k < 6; k++)
      for (int s = 0; s < 4; s++)
      begin
        r = mk(k, 16'(k * 16'h1234));
        r.ovr_en = 1'b1;
        r.ovr_seg = sag_pkg::sag_seg_t'(s);
        r.stk_op = sag_pkg::SAG_STK_PUSH;
        send(r);
      end
    // io ports around the reserved window
    for (int p = 16'h00F7; p <= 16'h0100; p++)
      send(mk(6, 16'(p)));
    send(mk(6, 16'h00F8));
    axi_rd(sag_pkg::OFS_STATUS, d, rr);
    chk("status io", d[1], 1'b1);
    chk("status vec", d[0], 1'b0);
    // fetch pointer advance by every nonzero length
    for (int n = 1; n < 8; n++)
    begin
      @(posedge core_clk);
      fetch_adv <= 1'b1;
      fetch_len <= 3'(n);
      @(posedge core_clk);
      fetch_adv <= 1'b0;
      sh[4] = sh[4] + 16'(n);
      send(mk(0, 16'h0000));
    end
    // random traffic with register rewrites
    repeat (300)
    begin
      if ($urandom_range(7, 0) == 0)
        axi_wr(8'(4 * $urandom_range(8, 0)), 16'($urandom), sag_pkg::RESP_OKAY);
      r = mk($urandom_range(5, 0), 16'h0000);
      d = $urandom;
      r.ovr_en = d[0];
      r.ovr_seg = sag_pkg::sag_seg_t'(d[2:1]);
      r.effective_offset = d[18:3];
      r.str_word = d[19];
      r.str_step = d[20];
      r.stk_op = $urandom_range(1, 0) ? sag_pkg::SAG_STK_PUSH : sag_pkg::SAG_STK_POP;
      send(r);
    end
    check_regs();
    chk("vector tally", vec_hits, exp_vec[15:0]);
    chk("io tally", rsv_io_hits, exp_rsv[15:0]);
    summarize();
  end
endmodule // segment_address_generator_bench
`default_nettype wire
